// ==== rtl/bmf_pkg.sv ====
// Constants, types and behaviour list of the bus-matching FIFO
// Behaviour
// - Store 36-bit words, write to read, fixed depth
// - Read port delivers 36, 18 or 9 bits
// - Both endian orders for word and byte sizes
// - Transfers only on clock edge with enables
// - Simultaneous write and read on one edge
// - Two mailboxes bypass array, read-port width
// - Each mailbox flags newly stored mail
// - Full reset clears pointers, latches flag programming
// - Partial reset clears pointers, keeps settings
// - Standard mode: every word needs a read
// - Fall-through: first word appears without read
// - Timing mode chosen by endian/timing pin
// - Standard mode: empty and full flags
// - Fall-through mode: input and output ready
// - Almost-full and almost-empty threshold flags
// - Full and almost-full two-stage synchronised, write side
// - Empty and almost-empty two-stage synchronised, read side
// - Offsets loaded parallel or serial by select
// - Flag selects pick method or default 8/16/64
// - Width and fall-through depth expansion without glue
// - Idle indication when no operation active
// - Almost-empty low when count at or below offset
// - Almost-full low when free at or below offset
// - Big-endian reads most significant piece first
// - Bus-match and size choose read width
package bmf_pkg;
  // ********************************
  // Data widths and pieces
  // ********************************
  localparam int          WORD_W      = 36;
  localparam int          HALF_W      = 18;
  localparam int          BYTE_W      = 9;
  localparam logic [1:0]  SIZE_LONG   = 2'h0;
  localparam logic [1:0]  SIZE_WORD   = 2'h1;
  localparam logic [1:0]  SIZE_BYTE   = 2'h2;
  // ********************************
  // Flag select codes {hi,lo}
  // ********************************
  localparam logic [1:0]  FS_DEF8     = 2'h0;
  localparam logic [1:0]  FS_DEF16    = 2'h1;
  localparam logic [1:0]  FS_DEF64    = 2'h2;
  localparam logic [1:0]  FS_PROG     = 2'h3;
  localparam int          DEF_OFF8    = 8;
  localparam int          DEF_OFF16   = 16;
  localparam int          DEF_OFF64   = 64;
  // ********************************
  // Wishbone register map
  // ********************************
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_STATUS  = 4'h4;
  localparam logic [3:0]  REG_AE_OFF  = 4'h8;
  localparam logic [3:0]  REG_AF_OFF  = 4'hC;
  localparam int          CTRL_PRST   = 0;
  // ********************************
  // Configuration sequence
  // ********************************
  typedef enum logic [4:0] {
    BMF_CFG_RESET = 5'h01,
    BMF_CFG_SER   = 5'h02,
    BMF_CFG_PAR_E = 5'h04,
    BMF_CFG_PAR_F = 5'h08,
    BMF_CFG_RUN   = 5'h10
  } bmf_cfg_t;
endpackage : bmf_pkg

// ==== rtl/bmf_fifo.sv ====
// Bus-matching synchronous FIFO with mailboxes and programmable flags
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module bmf_fifo import bmf_pkg::*; #(
  parameter int DEPTH = 1024
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               partial_rst_i,
  input  wire logic               endian_timing_select_i,
  input  wire logic               flag_select_lo_i,
  input  wire logic               flag_select_hi_i,
  input  wire logic               serial_prog_select_n_i,
  input  wire logic               serial_offset_in_i,
  input  wire logic               serial_load_i,
  input  wire logic               bus_match_select_i,
  input  wire logic               size_byte_i,
  input  wire logic               wr_en_i,
  input  wire logic               wr_mail_i,
  input  wire logic [WORD_W-1:0]  wr_data_i,
  input  wire logic               mail_two_rd_i,
  output logic      [WORD_W-1:0]  mail_two_data_o,
  input  wire logic               rd_en_i,
  input  wire logic               rd_mail_i,
  input  wire logic               rd_mail_wr_i,
  input  wire logic [WORD_W-1:0]  rd_mail_data_i,
  output logic      [WORD_W-1:0]  rd_data_o,
  output logic                    full_flag_n_o,
  output logic                    empty_flag_n_o,
  output logic                    near_full_n_o,
  output logic                    near_empty_n_o,
  output logic                    mailbox_one_flag_n_o,
  output logic                    mailbox_two_flag_n_o,
  output logic                    fall_through_mode_o,
  output logic                    idle_o,
  input  wire logic [3:0]         wb_adr_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic               wb_we_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  output logic                    wb_ack_o
);
  localparam int AW = $clog2(DEPTH);

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    bmf_cfg_t          cfg;
    logic              be;
    logic              fall_through_mode;
    logic              mode_pend;
    logic [1:0]        fs;
    logic              spm_n;
    logic [AW-1:0]     ae_off;
    logic [AW-1:0]     af_off;
    logic [AW:0]       sh_cnt;
    logic [AW-1:0]     wp;
    logic [AW-1:0]     rp;
    logic [AW:0]       cnt;
    logic [WORD_W-1:0] head;
    logic              head_v;
    logic [1:0]        idx;
    logic [WORD_W-1:0] dout;
    logic [WORD_W-1:0] mb1;
    logic              mb1_new;
    logic [WORD_W-1:0] mb2;
    logic              mb2_new;
    logic [WORD_W-1:0] mb2_out;
    logic [1:0]        ff_s;
    logic [1:0]        af_s;
    logic [1:0]        ef_s;
    logic [1:0]        ae_s;
    logic              ack;
    logic [31:0]       wb_dat;
  } bmf_state_t;

  bmf_state_t        st_ff;
  bmf_state_t        nxt_st;
  logic [WORD_W-1:0] mem [DEPTH];
  logic              mem_we;

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [1:0] last_idx(input logic [1:0] size);
    case (size)
      SIZE_WORD: last_idx = 2'h1;
      SIZE_BYTE: last_idx = 2'h3;
      default:   last_idx = 2'h0;
    endcase
  endfunction : last_idx

  function automatic logic [WORD_W-1:0] piece(input logic [WORD_W-1:0] w, input logic [1:0] i,
                                              input logic [1:0] size, input logic be);
    logic [1:0] p;
    p     = be ? last_idx(size) - i : i;
    piece = '0;
    case (size)
      SIZE_WORD: piece[HALF_W-1:0] = w[p[0]*HALF_W +: HALF_W];
      SIZE_BYTE: piece[BYTE_W-1:0] = w[p*BYTE_W +: BYTE_W];
      default:   piece = w;
    endcase
  endfunction : piece

  function automatic logic [WORD_W-1:0] width_mask(input logic [WORD_W-1:0] w, input logic [1:0] size);
    case (size)
      SIZE_WORD: width_mask = {{(WORD_W-HALF_W){1'b0}}, w[HALF_W-1:0]};
      SIZE_BYTE: width_mask = {{(WORD_W-BYTE_W){1'b0}}, w[BYTE_W-1:0]};
      default:   width_mask = w;
    endcase
  endfunction : width_mask

  // ********************************
  // Combinational control
  // ********************************
  logic [1:0]        size;
  logic              running;
  logic              do_wr;
  logic              do_pop;
  logic              do_rd;
  logic              wb_req;
  logic              prst;
  logic [AW:0]       total;
  logic [AW:0]       free;
  logic [WORD_W-1:0] mem_q;

  assign size    = bus_match_select_i ? (size_byte_i ? SIZE_BYTE : SIZE_WORD) : SIZE_LONG;
  assign running = (st_ff.cfg == BMF_CFG_RUN);
  assign wb_req  = wb_cyc_i && wb_stb_i && !st_ff.ack;
  assign prst    = partial_rst_i || (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL
                   && wb_dat_i[CTRL_PRST]);
  assign mem_q   = mem[st_ff.rp];
  assign total   = st_ff.cnt + {{AW{1'b0}}, st_ff.head_v};
  assign free    = (AW+1)'(DEPTH) - st_ff.cnt;
  // Internal full is used for blocking, so the delayed pin flag cannot let a word overrun
  assign do_wr   = running && wr_en_i && !wr_mail_i && st_ff.cnt != (AW+1)'(DEPTH) && !prst;
  assign mem_we  = do_wr;

  always_comb begin
    do_rd  = 1'b0;
    do_pop = 1'b0;
    if (running && !prst && rd_en_i && !rd_mail_i) begin
      if (st_ff.fall_through_mode) begin
        do_rd  = st_ff.head_v;
        do_pop = st_ff.head_v && st_ff.idx == last_idx(size) && st_ff.cnt != '0;
      end else begin
        do_rd  = st_ff.idx != 2'h0 || st_ff.cnt != '0;
        do_pop = st_ff.idx == 2'h0 && st_ff.cnt != '0;
      end
    end
    if (running && !prst && st_ff.fall_through_mode && !st_ff.head_v && st_ff.cnt != '0) begin
      do_pop = 1'b1;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    // Configuration
    if (st_ff.mode_pend) begin
      nxt_st.mode_pend = 1'b0;
      nxt_st.fall_through_mode      = !endian_timing_select_i;
    end
    case (st_ff.cfg)
      BMF_CFG_RESET: begin
        case (st_ff.fs)
          FS_DEF8:  nxt_st.ae_off = AW'(DEF_OFF8);
          FS_DEF16: nxt_st.ae_off = AW'(DEF_OFF16);
          FS_DEF64: nxt_st.ae_off = AW'(DEF_OFF64);
          default:  nxt_st.ae_off = st_ff.ae_off;
        endcase
        nxt_st.af_off = nxt_st.ae_off;
        if (st_ff.fs != FS_PROG) begin
          nxt_st.cfg = BMF_CFG_RUN;
        end else if (!st_ff.spm_n) begin
          nxt_st.cfg = BMF_CFG_SER;
        end else begin
          nxt_st.cfg = BMF_CFG_PAR_E;
        end
      end
      BMF_CFG_SER: begin
        if (serial_load_i) begin
          // Bits shift in almost-empty first, MSB first, then almost-full
          {nxt_st.ae_off, nxt_st.af_off} = {st_ff.ae_off[AW-2:0], st_ff.af_off, serial_offset_in_i};
          nxt_st.sh_cnt = st_ff.sh_cnt + 1'b1;
          if (st_ff.sh_cnt == (AW+1)'(2*AW-1)) begin
            nxt_st.cfg = BMF_CFG_RUN;
          end
        end
      end
      BMF_CFG_PAR_E: begin
        if (wr_en_i) begin
          nxt_st.ae_off = wr_data_i[AW-1:0];
          nxt_st.cfg    = BMF_CFG_PAR_F;
        end
      end
      BMF_CFG_PAR_F: begin
        if (wr_en_i) begin
          nxt_st.af_off = wr_data_i[AW-1:0];
          nxt_st.cfg    = BMF_CFG_RUN;
        end
      end
      BMF_CFG_RUN: begin
        nxt_st.cfg = BMF_CFG_RUN;
      end
      default: nxt_st.cfg = BMF_CFG_RESET;
    endcase
    // Array pointers and count
    if (do_wr) begin
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (do_pop) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(do_wr) - (AW+1)'(do_pop);
    // Read side piece sequencing
    if (st_ff.fall_through_mode) begin
      if (do_rd && st_ff.idx == last_idx(size)) begin
        nxt_st.head_v = do_pop;
        nxt_st.idx    = 2'h0;
      end else if (do_rd) begin
        nxt_st.idx = st_ff.idx + 2'h1;
      end else if (do_pop) begin
        nxt_st.head_v = 1'b1;
      end
      if (do_pop) begin
        nxt_st.head = mem_q;
      end
      nxt_st.dout = piece(nxt_st.head, nxt_st.idx, size, st_ff.be);
    end else if (do_rd) begin
      if (do_pop) begin
        nxt_st.head = mem_q;
      end
      nxt_st.dout = piece(nxt_st.head, st_ff.idx, size, st_ff.be);
      nxt_st.idx  = (st_ff.idx == last_idx(size)) ? 2'h0 : st_ff.idx + 2'h1;
    end
    // Mailboxes: a new store wins over a read in the same cycle
    if (rd_en_i && rd_mail_i) begin
      nxt_st.dout    = width_mask(st_ff.mb1, size);
      nxt_st.mb1_new = 1'b0;
    end
    if (wr_en_i && wr_mail_i) begin
      nxt_st.mb1     = width_mask(wr_data_i, size);
      nxt_st.mb1_new = 1'b1;
    end
    if (mail_two_rd_i) begin
      nxt_st.mb2_out = st_ff.mb2;
      nxt_st.mb2_new = 1'b0;
    end
    if (rd_mail_wr_i) begin
      nxt_st.mb2     = width_mask(rd_mail_data_i, size);
      nxt_st.mb2_new = 1'b1;
    end
    // Flush keeps offsets, method and modes
    if (prst) begin
      nxt_st.wp     = '0;
      nxt_st.rp     = '0;
      nxt_st.cnt    = '0;
      nxt_st.head_v = 1'b0;
      nxt_st.idx    = 2'h0;
    end
    // Two-stage flag pipelines; the raw flag enters stage one only
    nxt_st.ff_s = {st_ff.ff_s[0], running && st_ff.cnt != (AW+1)'(DEPTH)};
    nxt_st.af_s = {st_ff.af_s[0], running && free > (AW+1)'(st_ff.af_off)};
    nxt_st.ef_s = {st_ff.ef_s[0], st_ff.fall_through_mode ? st_ff.head_v
                                             : (st_ff.cnt != '0 || st_ff.idx != 2'h0)};
    nxt_st.ae_s = {st_ff.ae_s[0], total > (AW+1)'(st_ff.ae_off)};
    // Wishbone slave, one wait state
    nxt_st.ack    = wb_req;
    nxt_st.wb_dat = '0;
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        REG_STATUS: nxt_st.wb_dat = 32'({st_ff.cnt, 6'h0, st_ff.fall_through_mode, st_ff.be, running,
                                     st_ff.mb2_new, st_ff.mb1_new, st_ff.ae_s[1], st_ff.af_s[1],
                                     st_ff.ef_s[1], st_ff.ff_s[1]});
        REG_AE_OFF: nxt_st.wb_dat = 32'(st_ff.ae_off);
        REG_AF_OFF: nxt_st.wb_dat = 32'(st_ff.af_off);
        default:    nxt_st.wb_dat = '0;
      endcase
    end
    // Full reset: pointers to start, endian and flag programming caught while held, timing mode on the first edge after release
    if (rst_i) begin
      nxt_st           = '0;
      nxt_st.cfg       = BMF_CFG_RESET;
      nxt_st.be        = endian_timing_select_i;
      nxt_st.fs        = {flag_select_hi_i, flag_select_lo_i};
      nxt_st.spm_n     = serial_prog_select_n_i;
      nxt_st.mode_pend = 1'b1;
      nxt_st.fall_through_mode      = st_ff.fall_through_mode;
    end
  end

  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  // Array has no reset; a flush only moves the pointers
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[st_ff.wp] <= wr_data_i;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  // Polarity: 1 means room on the write side and data on the read side in both modes;
  // this lets a fall-through chain link ready to enable directly
  assign full_flag_n_o        = st_ff.ff_s[1];
  assign near_full_n_o        = st_ff.af_s[1];
  assign empty_flag_n_o       = st_ff.ef_s[1];
  assign near_empty_n_o       = st_ff.ae_s[1];
  assign mailbox_one_flag_n_o = !st_ff.mb1_new;
  assign mailbox_two_flag_n_o = !st_ff.mb2_new;
  assign fall_through_mode_o  = st_ff.fall_through_mode;
  assign rd_data_o            = st_ff.dout;
  assign mail_two_data_o      = st_ff.mb2_out;
  assign idle_o               = !(wr_en_i || rd_en_i || rd_mail_wr_i || mail_two_rd_i || serial_load_i
                                  || wb_cyc_i || prst) && !do_pop;
  assign wb_ack_o             = st_ff.ack;
  assign wb_dat_o             = st_ff.wb_dat;
endmodule : bmf_fifo

// ==== dv/bmf_fifo_sva.sv ====
// Port-level checker for the bus-matching FIFO
`timescale 1ns/1ps
module bmf_fifo_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic wr_mail_i,
  input wire logic rd_en_i,
  input wire logic rd_mail_wr_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic full_flag_n_o,
  input wire logic empty_flag_n_o,
  input wire logic near_full_n_o,
  input wire logic near_empty_n_o,
  input wire logic mailbox_one_flag_n_o,
  input wire logic mailbox_two_flag_n_o,
  input wire logic fall_through_mode_o,
  input wire logic idle_o
);
  default clocking cb @(posedge clk_i); endclocking
  // ********************************
  // Sequences
  // ********************************
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_mail_in;
    wr_en_i && wr_mail_i;
  endsequence
  // ********************************
  // Assertions
  // ********************************
  a_rst_status: assert property (rst_i |=> !full_flag_n_o && !empty_flag_n_o && !near_full_n_o && !near_empty_n_o)
    else $error("status flags not cleared by reset");
  a_rst_mail: assert property (rst_i |=> mailbox_one_flag_n_o && mailbox_two_flag_n_o)
    else $error("mail flags not idle after reset");
  a_wb_ack_next: assert property (disable iff (rst_i) s_wb_req |=> wb_ack_o)
    else $error("bus ack missing one cycle after request");
  a_wb_ack_pulse: assert property (disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  a_idle_busy: assert property (disable iff (rst_i) (wr_en_i || rd_en_i) |-> !idle_o)
    else $error("idle shown while a port is enabled");
  a_mail_one_new: assert property (disable iff (rst_i) s_mail_in |=> !mailbox_one_flag_n_o)
    else $error("mailbox one flag not set by store");
  a_mail_two_new: assert property (disable iff (rst_i) rd_mail_wr_i |=> !mailbox_two_flag_n_o)
    else $error("mailbox two flag not set by store");
  // Full can only appear three edges after a write, through the two-stage path
  a_full_cause: assert property (disable iff (rst_i) $fell(full_flag_n_o) |-> $past(wr_en_i, 3))
    else $error("full flag fell without a write three cycles before");
  a_full_near: assert property (disable iff (rst_i) !full_flag_n_o |-> !near_full_n_o)
    else $error("full without almost-full");
  a_empty_near: assert property (disable iff (rst_i) !fall_through_mode_o && !empty_flag_n_o |-> !near_empty_n_o)
    else $error("empty without almost-empty");
  a_mode_static: assert property (disable iff (rst_i) !$past(rst_i) && !$past(rst_i, 2) |-> $stable(fall_through_mode_o))
    else $error("timing mode changed while running");
endmodule : bmf_fifo_sva
bind bmf_fifo bmf_fifo_sva u_sva (.clk_i, .rst_i, .wr_en_i, .wr_mail_i, .rd_en_i, .rd_mail_wr_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .full_flag_n_o, .empty_flag_n_o, .near_full_n_o, .near_empty_n_o,
  .mailbox_one_flag_n_o, .mailbox_two_flag_n_o, .fall_through_mode_o, .idle_o);

// ==== dv/bmf_reader_model.sv ====
// Read-port consumer model: issues reads and keeps what comes back
`timescale 1ns/1ps
module bmf_reader_model import bmf_pkg::*; (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              start_i,
  input  wire logic [4:0]        count_i,
  input  wire logic              slow_i,
  input  wire logic [WORD_W-1:0] rd_data_i,
  output logic                   rd_en_o,
  output logic                   busy_o
);
  logic [4:0]        left;
  logic [4:0]        idx;
  logic              took;
  logic [WORD_W-1:0] got [0:31];
  assign busy_o = (left != 5'h00) || rd_en_o || took;
  always @(posedge clk_i) begin
    if (rst_i || start_i) begin
      left <= rst_i ? 5'h00 : count_i;
      idx <= 5'h00;
      rd_en_o <= 1'b0;
      took <= 1'b0;
    end else begin
      took <= rd_en_o;
      // Data of a read is valid after its edge, so it is taken one edge later
      if (took) begin
        got[idx] <= rd_data_i;
        idx <= idx + 5'h01;
      end
      // Enable changes only after an edge; slow mode leaves a gap between reads
      if (left != 5'h00 && !(slow_i && rd_en_o)) begin
        rd_en_o <= 1'b1;
        left <= left - 5'h01;
      end else begin
        rd_en_o <= 1'b0;
      end
    end
  end
endmodule : bmf_reader_model

// ==== dv/bmf_fifo_test.sv ====
// Self-checking testbench of the bus-matching FIFO
`timescale 1ns/1ps
module bmf_fifo_test import bmf_pkg::*;;
  logic clk_i, rst_i, partial_rst_i, endian_timing_select_i, flag_select_lo_i, flag_select_hi_i;
  logic serial_prog_select_n_i, serial_offset_in_i, serial_load_i, bus_match_select_i, size_byte_i;
  logic wr_en_i, wr_mail_i, mail_two_rd_i, rd_mail_i, rd_mail_wr_i, tb_rd, m_rd, m_busy, m_go, m_slow;
  logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, idle_o, fall_through_mode_o;
  logic full_flag_n_o, empty_flag_n_o, near_full_n_o, near_empty_n_o, mailbox_one_flag_n_o, mailbox_two_flag_n_o;
  logic [WORD_W-1:0] wr_data_i, rd_mail_data_i, rd_data_o, mail_two_data_o;
  logic [31:0] wb_dat_i, wb_dat_o, d;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [4:0]  m_cnt;
  wire         rd_en_i = m_rd | tb_rd;
  int          err_count, tests_run, cyc;
  bmf_fifo #(.DEPTH(16)) dut (.clk_i, .rst_i, .partial_rst_i, .endian_timing_select_i, .flag_select_lo_i,
    .flag_select_hi_i, .serial_prog_select_n_i, .serial_offset_in_i, .serial_load_i, .bus_match_select_i,
    .size_byte_i, .wr_en_i, .wr_mail_i, .wr_data_i, .mail_two_rd_i, .mail_two_data_o, .rd_en_i, .rd_mail_i,
    .rd_mail_wr_i, .rd_mail_data_i, .rd_data_o, .full_flag_n_o, .empty_flag_n_o, .near_full_n_o,
    .near_empty_n_o, .mailbox_one_flag_n_o, .mailbox_two_flag_n_o, .fall_through_mode_o, .idle_o,
    .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
  bmf_reader_model u_rd (.clk_i, .rst_i, .start_i(m_go), .count_i(m_cnt), .slow_i(m_slow),
    .rd_data_i(rd_data_o), .rd_en_o(m_rd), .busy_o(m_busy));
  // ********************************
  // Helpers
  // ********************************
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  function automatic logic [35:0] word(input int k);
    return {4'hA, 16'h5A5A ^ k[15:0], k[15:0]};
  endfunction : word
  task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // Classic single read; the slave answers after one wait state
  task automatic wb_rd(input logic [3:0] adr);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= 1'b0;
    wb_adr_i <= adr;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_rd
  // Classic single write; the ack ends the wait, which has no limit but the hang guard
  task automatic wb_wr(input logic [3:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= 1'b1;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_wr
  task automatic wr(input int n, input int base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      wr_en_i <= 1'b1;
      wr_data_i <= word(base + i);
    end
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask : wr
  task automatic rd(input int n, input logic slow);
    int k;
    k = 0;
    @(posedge clk_i);
    m_go <= 1'b1;
    m_cnt <= 5'(n);
    m_slow <= slow;
    @(posedge clk_i);
    m_go <= 1'b0;
    do begin
      @(posedge clk_i);
      k++;
    end while (m_busy !== 1'b0 && k < 200);
  endtask : rd
  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset;
    rst_i <= 1'b1;
    tick(4);
    chk("full_rst", full_flag_n_o, 36'h0);
    chk("mb1_rst", mailbox_one_flag_n_o, 36'h1);
    rst_i <= 1'b0;
    tick(8);
    wb_rd(REG_AE_OFF);
    chk("ae_off", {4'h0, d}, DEF_OFF8);
    wb_rd(REG_AF_OFF);
    chk("af_off", {4'h0, d}, DEF_OFF8);
    wb_rd(REG_STATUS);
    chk("mode", {33'h0, d[8:6]}, 36'h3);
    wb_rd(4'h2);
    chk("unmapped", {4'h0, d}, 36'h0);
    chk("empty_init", empty_flag_n_o, 36'h0);
  endtask : t_reset
  task automatic t_fill;
    wr(8, 0);
    tick(4);
    chk("near_empty8", near_empty_n_o, 36'h0);
    chk("empty8", empty_flag_n_o, 36'h1);
    wr(1, 8);
    tick(4);
    chk("near_empty9", near_empty_n_o, 36'h1);
    // Seventeenth write meets a full array and must be dropped
    wr(8, 9);
    tick(4);
    chk("full", full_flag_n_o, 36'h0);
    chk("near_full", near_full_n_o, 36'h0);
    rd(16, 1'b1);
    for (int i = 0; i < 16; i++) chk("drain", u_rd.got[i], word(i));
    tick(4);
    chk("empty_drain", empty_flag_n_o, 36'h0);
    wr(3, 20);
    rd(3, 1'b0);
    for (int i = 0; i < 3; i++) chk("wrap", u_rd.got[i], word(20 + i));
  endtask : t_fill
  task automatic t_mail;
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    wr_mail_i <= 1'b1;
    wr_data_i <= word(99);
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    wr_mail_i <= 1'b0;
    rd_mail_wr_i <= 1'b1;
    rd_mail_data_i <= word(77);
    @(posedge clk_i);
    rd_mail_wr_i <= 1'b0;
    tick(2);
    chk("mb1_new", mailbox_one_flag_n_o, 36'h0);
    chk("mb2_new", mailbox_two_flag_n_o, 36'h0);
    chk("mb_bypass", empty_flag_n_o, 36'h0);
    tb_rd <= 1'b1;
    rd_mail_i <= 1'b1;
    mail_two_rd_i <= 1'b1;
    @(posedge clk_i);
    tb_rd <= 1'b0;
    rd_mail_i <= 1'b0;
    mail_two_rd_i <= 1'b0;
    @(posedge clk_i);
    chk("mb1_data", rd_data_o, word(99));
    chk("mb2_data", mail_two_data_o, word(77));
    chk("mb1_clr", mailbox_one_flag_n_o, 36'h1);
    chk("mb2_clr", mailbox_two_flag_n_o, 36'h1);
  endtask : t_mail
  task automatic t_flush;
    wr(2, 40);
    tick(4);
    chk("pre_flush", empty_flag_n_o, 36'h1);
    partial_rst_i <= 1'b1;
    @(posedge clk_i);
    partial_rst_i <= 1'b0;
    tick(4);
    chk("flushed", empty_flag_n_o, 36'h0);
    wb_rd(REG_AE_OFF);
    chk("ae_kept", {4'h0, d}, DEF_OFF8);
    wr(1, 50);
    rd(1, 1'b0);
    chk("after_flush", u_rd.got[0], word(50));
  endtask : t_flush
  // Second full reset: big-endian bytes, fall-through, parallel offsets
  task automatic t_fall_through_mode;
    logic [35:0] w;
    w = word(7);
    @(posedge clk_i);
    rst_i <= 1'b1;
    bus_match_select_i <= 1'b1;
    size_byte_i <= 1'b1;
    {flag_select_hi_i, flag_select_lo_i} <= FS_PROG;
    tick(4);
    rst_i <= 1'b0;
    endian_timing_select_i <= 1'b0;
    tick(4);
    wr(1, 3);
    wr(1, 5);
    wb_rd(REG_AE_OFF);
    chk("par_ae", {4'h0, d}, 36'h3);
    wb_rd(REG_AF_OFF);
    chk("par_af", {4'h0, d}, 36'h5);
    wb_rd(REG_STATUS);
    chk("mode_fall_through_mode", {33'h0, d[8:6]}, 36'h7);
    wr(1, 7);
    tick(4);
    chk("out_ready", empty_flag_n_o, 36'h1);
    chk("fall_first", rd_data_o, 36'(w[35:27]));
    rd(3, 1'b0);
    chk("byte1", u_rd.got[0], 36'(w[26:18]));
    chk("byte2", u_rd.got[1], 36'(w[17:9]));
    chk("byte3", u_rd.got[2], 36'(w[8:0]));
    wb_wr(REG_CTRL, 32'h1);
    tick(4);
    chk("bus_flush", empty_flag_n_o, 36'h0);
    wb_rd(REG_AE_OFF);
    chk("ae_kept2", {4'h0, d}, 36'h3);
  endtask : t_fall_through_mode
  // ********************************
  // Main sequence and hang guard
  // ********************************
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      report_and_stop;
    end
  end
  initial begin
    {rst_i, partial_rst_i, serial_offset_in_i, serial_load_i, bus_match_select_i, size_byte_i} = '0;
    {wr_en_i, wr_mail_i, mail_two_rd_i, rd_mail_i, rd_mail_wr_i, tb_rd, m_go, m_slow} = '0;
    {wb_we_i, wb_cyc_i, wb_stb_i, wb_dat_i, wr_data_i, rd_mail_data_i, wb_adr_i, m_cnt} = '0;
    {flag_select_hi_i, flag_select_lo_i} = FS_DEF8;
    serial_prog_select_n_i = 1'b1;
    endian_timing_select_i = 1'b1;
    wb_sel_i = 4'hF;
    t_reset();
    t_fill();
    t_mail();
    t_flush();
    t_fall_through_mode();
    report_and_stop();
  end
endmodule : bmf_fifo_test
